/* tbi_defs.svh */
// Constants for the trace buffer identification register.
// Assumes inclusion by bare name from the package and modules.
`ifndef TBI_DEFS_SVH
`define TBI_DEFS_SVH
`define TBI_WIDTH 64
`define TBI_FLAG_BIT 5
`define TBI_BLOCK_BIT 4
`define TBI_ALIGN_LSB 0
`define TBI_ALIGN_MSB 3
`define TBI_ALIGN_MAX 4'hb
`define TBI_OWNER_EL2_ONLY 2'h0
`define TBI_EL0 2'h0
`define TBI_EL1 2'h1
`define TBI_EL2 2'h2
`define TBI_EL3 2'h3
`endif

/* tbi_pkg.sv */
// Types for the trace buffer identification register.
// Assumes tbi_defs.svh is on the include path.
`default_nettype none
`include "tbi_defs.svh"
package tbi_pkg;
    typedef enum logic [1:0] {TBI_SEC_SECURE, TBI_SEC_NONSECURE, TBI_SEC_REALM, TBI_SEC_RSVD} tbi_sec_type;
    typedef struct packed {
        logic [1:0] el;
        tbi_sec_type state;
    } tbi_ctx_type;
    typedef struct packed {
        logic owner_select;
        logic owner_extension;
        logic [1:0] el2_owner;
        logic sec_el2_enable;
    } tbi_ctl_type;
    typedef struct packed {
        logic has_feature;
        logic has_el3;
        logic has_el2;
        logic has_sec_el2;
        logic has_realm;
    } tbi_cfg_type;
    typedef struct packed {
        logic [`TBI_WIDTH-1:0] data;
        logic ack;
        logic undef;
    } tbi_state_type;
endpackage
`default_nettype wire

/* tbi_block_calc.sv */
// Combinational programming-blocked evaluation.
// Assumes stable context and controls from the same clock domain.
`default_nettype none
`include "tbi_defs.svh"
module tbi_block_calc
    import tbi_pkg::*;
(
    // Context and controls
    input wire tbi_ctx_type i_ctx,
    input wire tbi_ctl_type i_ctl,
    input wire tbi_cfg_type i_cfg,
    // Result
    output logic o_blocked
);
    tbi_sec_type owner;
    logic el1;
    logic el2;
    logic e2tb0;
    logic st_s;
    logic st_ns;
    logic st_r;
    always_comb
    begin
        if (i_cfg.has_realm && i_ctl.owner_extension && i_ctl.owner_select)
            owner = TBI_SEC_REALM;
        else if (i_ctl.owner_select)
            owner = TBI_SEC_NONSECURE;
        else
            owner = TBI_SEC_SECURE;
        el1 = (i_ctx.el == `TBI_EL1);
        el2 = (i_ctx.el == `TBI_EL2);
        e2tb0 = (i_ctl.el2_owner == `TBI_OWNER_EL2_ONLY);
        st_s = (i_ctx.state == TBI_SEC_SECURE);
        st_ns = (i_ctx.state == TBI_SEC_NONSECURE);
        st_r = (i_ctx.state == TBI_SEC_REALM);
        o_blocked = 1'b0;
        if (i_ctx.el == `TBI_EL3 || i_ctx.el == `TBI_EL0)
            o_blocked = 1'b0;
        else if (i_cfg.has_el3 && owner == TBI_SEC_SECURE)
            o_blocked = (st_ns && (el1 || el2)) || (i_cfg.has_realm && st_r && (el1 || el2))
                || (st_s && el1 && i_cfg.has_sec_el2 && i_ctl.sec_el2_enable && e2tb0);
        else if (i_cfg.has_el3 && owner == TBI_SEC_NONSECURE)
            o_blocked = (st_s && el1) || (st_s && el2 && i_cfg.has_sec_el2)
                || (st_ns && el1 && i_cfg.has_el2 && e2tb0)
                || (i_cfg.has_realm && st_r && (el1 || el2));
        else if (i_cfg.has_el3 && i_cfg.has_realm && owner == TBI_SEC_REALM)
            o_blocked = ((st_ns || st_s) && (el1 || el2)) || (st_r && el1 && e2tb0);
        else if (!i_cfg.has_el3 && i_cfg.has_el2 && e2tb0)
            o_blocked = el1;
    end
endmodule // tbi_block_calc
`default_nettype wire

/* tbi_id_reg.sv */
// Trace buffer identification register, read by system-register reads.
// Assumes read strobe and context come from core logic on i_core_clk.
//
// Contract
// - 64-bit register, undefined without the feature.
// - Flag field zero disables hardware flag management.
// - Flag field one follows owning regime controls.
// - No hardware access flag: missing flag faults.
// - No hardware dirty state: modifier ignored, may fault.
// - Flag field is read-only.
// - Blocked field reads zero at EL3.
// - Blocked one when owned elsewhere, else zero.
// - Secure owner blocking cases with EL3.
// - Non-secure owner blocking cases with EL3.
// - Realm owner blocking cases.
// - No EL3: EL1 blocked if control 0b00; else zero.
// - Alignment field bits 3:0, codes up to 2KB.
`default_nettype none
`include "tbi_defs.svh"
module tbi_id_reg
    import tbi_pkg::*;
#(
    parameter logic FLAG_UPDATES = 1'b1,
    parameter logic [3:0] ALIGN_CODE = 4'h3
)
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Configuration and controls
    input wire tbi_cfg_type i_cfg,
    input wire tbi_ctl_type i_ctl,
    input wire tbi_ctx_type i_ctx,
    // Access
    input wire logic i_read,
    input wire logic i_write,
    // Answer
    output logic [`TBI_WIDTH-1:0] o_data,
    output logic o_ack,
    output logic o_undef
);
    tbi_state_type state;
    tbi_state_type next_state;
    logic blocked;
    logic [3:0] align_safe;

    // ------------------------------------------------
    // Read value
    // ------------------------------------------------
    tbi_block_calc u_calc (
        .i_ctx(i_ctx),
        .i_ctl(i_ctl),
        .i_cfg(i_cfg),
        .o_blocked(blocked)
    );

    assign align_safe = (ALIGN_CODE > `TBI_ALIGN_MAX) ? `TBI_ALIGN_MAX : ALIGN_CODE;

    always_comb
    begin
        next_state = state;
        next_state.ack = 1'b0;
        next_state.undef = 1'b0;
        if (i_read || i_write)
        begin
            if (!i_cfg.has_feature || i_ctx.el == `TBI_EL0 || i_write)
            begin
                next_state.undef = 1'b1;
                next_state.data = '0;
            end
            else
            begin
                next_state.ack = 1'b1;
                next_state.data = '0;
                next_state.data[`TBI_FLAG_BIT] = FLAG_UPDATES;
                next_state.data[`TBI_BLOCK_BIT] = blocked;
                next_state.data[`TBI_ALIGN_MSB:`TBI_ALIGN_LSB] = align_safe;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            state <= '0;
        else
            state <= next_state;
    end

    assign o_data = state.data;
    assign o_ack = state.ack;
    assign o_undef = state.undef;

    // ------------------------------------------------
    // Checks
    // ------------------------------------------------
    a_el3_zero: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_read && !i_write && i_ctx.el == `TBI_EL3 && i_cfg.has_feature) |=> o_ack && !o_data[`TBI_BLOCK_BIT])
        else $error("blocked bit set at EL3");
    a_upper_zero: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        o_ack |-> o_data[`TBI_WIDTH-1:6] == '0)
        else $error("reserved bits nonzero");
    a_no_feature: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_read && !i_cfg.has_feature) |=> o_undef && !o_ack)
        else $error("read without feature not undefined");
    a_flag_const: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        o_ack |-> o_data[`TBI_FLAG_BIT] == FLAG_UPDATES)
        else $error("flag field changed");
    a_fresh_read: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_read && !i_write && i_cfg.has_feature && i_ctx.el != `TBI_EL0)
        |=> o_ack && o_data[`TBI_BLOCK_BIT] == $past(blocked))
        else $error("blocked bit stale");
    a_write_ignored: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        i_write |=> !o_ack)
        else $error("write accepted");
    a_ns_blocked: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_read && !i_write && i_cfg.has_feature && i_cfg.has_el3 && !i_ctl.owner_select
        && !i_ctl.owner_extension && i_ctx.state == TBI_SEC_NONSECURE && i_ctx.el == `TBI_EL1)
        |=> o_data[`TBI_BLOCK_BIT])
        else $error("non-secure EL1 not blocked");
    a_noel3_el1: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_read && !i_write && i_cfg.has_feature && !i_cfg.has_el3 && i_cfg.has_el2
        && i_ctl.el2_owner == `TBI_OWNER_EL2_ONLY && i_ctx.el == `TBI_EL1) |=> o_data[`TBI_BLOCK_BIT])
        else $error("EL1 not blocked without EL3");

    // ------------------------------------------------
    // Check helpers
    // ------------------------------------------------
    logic chk_read;
    logic chk_el1;
    logic chk_el2;
    logic own_s;
    logic own_ns;
    logic own_r;

    assign chk_read = i_read && !i_write && i_cfg.has_feature && i_ctx.el != `TBI_EL0;
    assign chk_el1 = (i_ctx.el == `TBI_EL1);
    assign chk_el2 = (i_ctx.el == `TBI_EL2);
    assign own_r = i_cfg.has_realm && i_ctl.owner_extension && i_ctl.owner_select;
    assign own_ns = i_ctl.owner_select && !own_r;
    assign own_s = !i_ctl.owner_select;

    // ------------------------------------------------
    // Answer checks
    // ------------------------------------------------
    a_reset_quiet: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        $rose(i_nrst) |-> !o_ack && !o_undef && o_data == '0)
        else $error("outputs not clear after reset");

    a_idle_quiet: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (!i_read && !i_write) |=> !o_ack && !o_undef && $stable(o_data))
        else $error("answer without access");

    a_el0_undef: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_read && i_ctx.el == `TBI_EL0) |=> o_undef && !o_ack)
        else $error("read at EL0 not undefined");

    a_write_undef: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        i_write |=> o_undef && o_data == '0)
        else $error("write not refused");

    a_undef_clear: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        o_undef |-> !o_ack && o_data == '0)
        else $error("undefined answer carries data");

    a_ack_cause: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        o_ack |-> $past(chk_read))
        else $error("acknowledge without valid read");

    // ------------------------------------------------
    // Field checks
    // ------------------------------------------------
    a_align_range: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        o_ack |-> o_data[`TBI_ALIGN_MSB:`TBI_ALIGN_LSB] <= `TBI_ALIGN_MAX
        && (ALIGN_CODE > `TBI_ALIGN_MAX || o_data[`TBI_ALIGN_MSB:`TBI_ALIGN_LSB] == ALIGN_CODE))
        else $error("alignment code out of range");

    // ------------------------------------------------
    // Blocking checks
    // ------------------------------------------------
    a_s_realm_blk: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (chk_read && i_cfg.has_el3 && own_s && i_cfg.has_realm && i_ctx.state == TBI_SEC_REALM
        && (chk_el1 || chk_el2)) |=> o_ack && o_data[`TBI_BLOCK_BIT])
        else $error("realm level not blocked under secure owner");

    a_s_sel1_blk: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (chk_read && i_cfg.has_el3 && own_s && i_ctx.state == TBI_SEC_SECURE && chk_el1 && i_cfg.has_sec_el2
        && i_ctl.sec_el2_enable && i_ctl.el2_owner == `TBI_OWNER_EL2_ONLY) |=> o_ack && o_data[`TBI_BLOCK_BIT])
        else $error("secure EL1 not blocked under secure owner");

    a_ns_sec_blk: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (chk_read && i_cfg.has_el3 && own_ns && i_ctx.state == TBI_SEC_SECURE
        && (chk_el1 || (chk_el2 && i_cfg.has_sec_el2))) |=> o_ack && o_data[`TBI_BLOCK_BIT])
        else $error("secure level not blocked under non-secure owner");

    a_ns_el1_blk: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (chk_read && i_cfg.has_el3 && own_ns && i_ctx.state == TBI_SEC_NONSECURE && chk_el1 && i_cfg.has_el2
        && i_ctl.el2_owner == `TBI_OWNER_EL2_ONLY) |=> o_ack && o_data[`TBI_BLOCK_BIT])
        else $error("non-secure EL1 not blocked under non-secure owner");

    a_ns_realm_blk: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (chk_read && i_cfg.has_el3 && own_ns && i_cfg.has_realm && i_ctx.state == TBI_SEC_REALM
        && (chk_el1 || chk_el2)) |=> o_ack && o_data[`TBI_BLOCK_BIT])
        else $error("realm level not blocked under non-secure owner");

    a_r_other_blk: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (chk_read && i_cfg.has_el3 && own_r && (chk_el1 || chk_el2)
        && (i_ctx.state == TBI_SEC_SECURE || i_ctx.state == TBI_SEC_NONSECURE)) |=> o_ack && o_data[`TBI_BLOCK_BIT])
        else $error("other state not blocked under realm owner");

    a_r_el1_blk: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (chk_read && i_cfg.has_el3 && own_r && i_ctx.state == TBI_SEC_REALM && chk_el1
        && i_ctl.el2_owner == `TBI_OWNER_EL2_ONLY) |=> o_ack && o_data[`TBI_BLOCK_BIT])
        else $error("realm EL1 not blocked under realm owner");

    a_owner_free: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (chk_read && i_cfg.has_el3 && chk_el2 && ((own_s && i_ctx.state == TBI_SEC_SECURE)
        || (own_ns && i_ctx.state == TBI_SEC_NONSECURE) || (own_r && i_ctx.state == TBI_SEC_REALM)))
        |=> o_ack && !o_data[`TBI_BLOCK_BIT])
        else $error("owning EL2 blocked");

    a_noel3_free: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (chk_read && !i_cfg.has_el3 && (chk_el2 || !i_cfg.has_el2 || i_ctl.el2_owner != `TBI_OWNER_EL2_ONLY))
        |=> o_ack && !o_data[`TBI_BLOCK_BIT])
        else $error("unlisted case blocked without EL3");
endmodule // tbi_id_reg
`default_nettype wire

/* tbi_id_reg_tb.sv */
// Self-checking bench for the trace buffer identification register.
// Assumes tbi_pkg and tbi_defs.svh are compiled first.
`default_nettype none
`include "tbi_defs.svh"
module tbi_id_reg_tb
    import tbi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [3:0] ALN = 4'hb;
    logic i_core_clk = 1'b0;
    logic i_nrst = 1'b0;
    tbi_cfg_type cfg = '0;
    tbi_ctl_type ctl = '0;
    tbi_ctx_type ctx = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [`TBI_WIDTH-1:0] data;
    logic ack;
    logic undef;
    logic [`TBI_WIDTH-1:0] data2;
    logic ack2;
    logic undef2;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    // Each entry is configuration, controls, context and the expected blocked bit.
    logic [14:0] tbl [18] = '{{5'h1f, 5'h03, 4'h5, 1'b1}, {5'h1f, 5'h01, 4'h4, 1'b1},
        {5'h1f, 5'h03, 4'h4, 1'b0}, {5'h1f, 5'h10, 4'h5, 1'b1}, {5'h1f, 5'h12, 4'h9, 1'b0},
        {5'h1f, 5'h12, 4'h8, 1'b1}, {5'h1f, 5'h18, 4'h6, 1'b1}, {5'h1f, 5'h1a, 4'h6, 1'b0},
        {5'h1f, 5'h1a, 4'h9, 1'b1}, {5'h16, 5'h00, 4'h5, 1'b1}, {5'h16, 5'h02, 4'h5, 1'b0},
        {5'h1f, 5'h00, 4'ha, 1'b1}, {5'h1f, 5'h10, 4'h6, 1'b1}, {5'h1f, 5'h18, 4'h8, 1'b1},
        {5'h1f, 5'h01, 4'h8, 1'b0}, {5'h1f, 5'h18, 4'ha, 1'b0}, {5'h16, 5'h00, 4'h9, 1'b0},
        {5'h1e, 5'h18, 4'h5, 1'b1}};

    always #25 i_core_clk = ~i_core_clk;

    tbi_id_reg #(.FLAG_UPDATES(1'b1), .ALIGN_CODE(ALN)) DUT (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
        .i_cfg(cfg), .i_ctl(ctl), .i_ctx(ctx), .i_read(rd), .i_write(wr), .o_data(data), .o_ack(ack),
        .o_undef(undef));

    tbi_id_reg #(.FLAG_UPDATES(1'b0), .ALIGN_CODE(4'hf)) DUT2 (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
        .i_cfg(cfg), .i_ctl(ctl), .i_ctx(ctx), .i_read(rd), .i_write(wr), .o_data(data2), .o_ack(ack2),
        .o_undef(undef2));

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic access(input logic w, input logic [13:0] s, input logic [63:0] exp, input logic xu);
        int k;
        @(negedge i_core_clk);
        {cfg, ctl, ctx} = s;
        rd = ~w;
        wr = w;
        @(negedge i_core_clk);
        rd = 1'b0;
        wr = 1'b0;
        k = 0;
        while (!(ack === 1'b1 || undef === 1'b1) && k < 3)
        begin
            @(negedge i_core_clk);
            k++;
        end
        check(data, exp);
        check({63'h0, undef}, {63'h0, xu});
        check({63'h0, ack}, {63'h0, ~xu});
        check(data2, xu ? 64'h0 : {exp[63:6], 1'b0, exp[4], `TBI_ALIGN_MAX});
        check({62'h0, ack2, undef2}, {62'h0, ~xu, xu});
    endtask

    task automatic stop_test();
        $display("checks=%0d fails=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // --------------------------------------------------------------
    // Sequence
    // --------------------------------------------------------------
    always @(posedge i_core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 500)
        begin
            n_fail++;
            stop_test();
        end
    end

    initial
    begin
        repeat (10) @(negedge i_core_clk);
        i_nrst = 1'b1;
        access(1'b0, {5'h1f, 5'h10, 4'hd}, {58'h0, 1'b1, 1'b0, ALN}, 1'b0);
        $display("test fields done");
        access(1'b1, {5'h1f, 5'h10, 4'hd}, 64'h0, 1'b1);
        access(1'b0, {5'h1f, 5'h10, 4'hd}, {58'h0, 1'b1, 1'b0, ALN}, 1'b0);
        $display("test write done");
        access(1'b0, {5'h1f, 5'h10, 4'h1}, 64'h0, 1'b1);
        access(1'b0, {5'h0f, 5'h10, 4'h5}, 64'h0, 1'b1);
        $display("test undefined done");
        for (int i = 0; i < 18; i++)
            access(1'b0, tbl[i][14:1], {58'h0, 1'b1, tbl[i][0], ALN}, 1'b0);
        $display("test blocking done");
        stop_test();
    end
endmodule // tbi_id_reg_tb
`default_nettype wire
